// file: rtl/video_configuration_pkg.sv
// Package for the video output configuration block: register map, field layout, encodings.
// Assumes an AXI4-Lite master with 32-bit data on the system clock.
package video_configuration_pkg;
  // ==========================================================================
  // Register map
  localparam logic [3:0] VOC_ADDR_CONFIG = 4'h0;
  localparam logic [3:0] VOC_ADDR_STATUS = 4'h4;
  localparam logic [31:0] VOC_CONFIG_RESET = 32'h0000_0000;
  // ==========================================================================
  // Field positions
  localparam int VOC_MODE_HI = 30;
  localparam int VOC_MODE_LO = 29;
  localparam int VOC_DEPTH_BIT = 28;
  localparam int VOC_BCAST_BIT = 27;
  localparam int VOC_BASE_BIT = 26;
  localparam int VOC_AUDIO_HI = 25;
  localparam int VOC_AUDIO_LO = 23;
  localparam int VOC_GROUP_HI = 11;
  localparam int VOC_GROUP_LO = 9;
  localparam int VOC_MASK_HI = 7;
  localparam int VOC_MASK_LO = 0;
  // Writable bits; the gaps at 31, 22:12 and 8 read as zero.
  localparam logic [31:0] VOC_WRITE_MASK = 32'h7f80_0eff;
  localparam logic [1:0] VOC_RESP_OKAY = 2'h0;
  localparam logic [1:0] VOC_RESP_SLVERR = 2'h2;
  localparam logic [2:0] VOC_GROUP_LAST = 3'h3;
  localparam int VOC_GROUPS = 4;
  localparam int VOC_PINS = 32;
  localparam int VOC_CORES = 8;
  // ==========================================================================
  // Output modes
  typedef enum logic [1:0] {
    VOC_MODE_OFF = 2'h0,
    VOC_MODE_VGA = 2'h1,
    VOC_MODE_COMP1 = 2'h2,
    VOC_MODE_COMP2 = 2'h3
  } video_configuration_mode_e;
endpackage : video_configuration_pkg

// file: rtl/video_configuration_top.sv
// Video output configuration register of one core and its pin routing decode.
// Assumes the generator supplies the VGA byte and the broadcast and baseband nibbles on CLK_SYS.
// Notes on behaviour
// [R1] Each core instantiates its own copy; nothing is shared between cores.
// [R2] Reading the configuration register returns its stored contents.
// [R3] Color depth bit 28, broadcast color bit 27, baseband color bit 26.
// [R4] Mode 00 disables video; no pin is driven.
// [R5] Mode 01 drives 8-bit parallel VGA on all eight mask positions.
// [R6] Mode 10: broadcast on positions 7:4, baseband on 3:0.
// [R7] Mode 11: baseband on positions 7:4, broadcast on 3:0.
// [R8] Depth 0: 32 one-bit pixels per long (PIXELS_PER_LONG reports 31); depth 1: 16 two-bit pixels.
// [R9] Each color enable adds chroma to its signal when set.
// [R10] Three-bit audio select picks one core's PLL A as aural carrier.
// [R11] Group g routes to pins 8g+7..8g; groups 4-7 drive nothing; mask gates.
// [R12] Reset clears the register, leaving video disabled.
module video_configuration_top
  import video_configuration_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [7:0] VGA_DATA,
  input wire logic [3:0] BROADCAST_DATA,
  input wire logic [3:0] BASEBAND_DATA,
  input wire logic [VOC_CORES-1:0] CORE_PLL_A,
  output logic COLOR_DEPTH_SEL,
  output logic [4:0] PIXELS_PER_LONG,
  output logic BROADCAST_COLOR_EN,
  output logic BASEBAND_COLOR_EN,
  output logic AURAL_CARRIER,
  output logic VIDEO_ACTIVE,
  output logic [VOC_PINS-1:0] VIDEO_OUT,
  output logic [VOC_PINS-1:0] VIDEO_OE
);
  // ==========================================================================
  // Bus slave
  logic [31:0] video_configuration;
  logic aw_held, w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] next_config;
  logic [31:0] status_word;

  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (aw_held && w_held) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR[3:0];
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
    end
  end

  always_comb begin
    next_config = video_configuration;
    for (int b = 0; b < 4; b++) begin
      if (w_strb[b]) begin
        next_config[b*8 +: 8] = w_data[b*8 +: 8];
      end
    end
    next_config = next_config & VOC_WRITE_MASK;
  end

  // Only the configuration word is writable; the status word answers writes with SLVERR.
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      video_configuration <= VOC_CONFIG_RESET; // [R12]
    end else if (aw_held && w_held && aw_addr == VOC_ADDR_CONFIG) begin
      video_configuration <= next_config; // [R3]
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= VOC_RESP_OKAY;
    end else if (aw_held && w_held) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= (aw_addr == VOC_ADDR_CONFIG) ? VOC_RESP_OKAY : VOC_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= VOC_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= VOC_RESP_OKAY;
      unique case (S_AXI_ARADDR[3:0])
        VOC_ADDR_CONFIG: S_AXI_RDATA <= video_configuration; // [R2]
        VOC_ADDR_STATUS: S_AXI_RDATA <= status_word;
        default: begin
          S_AXI_RDATA <= 32'h0000_0000;
          S_AXI_RRESP <= VOC_RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // ==========================================================================
  // Field decode
  video_configuration_mode_e mode;
  logic [2:0] group_sel;
  logic [7:0] pin_mask;
  logic [2:0] audio_src;
  logic group_ok;
  logic [7:0] lane_data;

  assign mode = video_configuration_mode_e'(video_configuration[VOC_MODE_HI:VOC_MODE_LO]);
  assign group_sel = video_configuration[VOC_GROUP_HI:VOC_GROUP_LO];
  assign pin_mask = video_configuration[VOC_MASK_HI:VOC_MASK_LO];
  assign audio_src = video_configuration[VOC_AUDIO_HI:VOC_AUDIO_LO];
  assign group_ok = group_sel <= VOC_GROUP_LAST; // [R11]
  assign status_word = {30'h0, group_ok, VIDEO_ACTIVE};

  always_comb begin
    lane_data = 8'h00;
    unique case (mode)
      VOC_MODE_OFF: lane_data = 8'h00; // [R4]
      VOC_MODE_VGA: lane_data = VGA_DATA; // [R5]
      VOC_MODE_COMP1: lane_data = {BROADCAST_DATA, BASEBAND_DATA}; // [R6]
      VOC_MODE_COMP2: lane_data = {BASEBAND_DATA, BROADCAST_DATA}; // [R7]
    endcase
  end

  // The carrier input is a free-running clock from another core, so it is synchronised.
  logic aural_meta, aural_sync;
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      aural_meta <= 1'b0;
      aural_sync <= 1'b0;
    end else begin
      aural_meta <= CORE_PLL_A[audio_src]; // [R10]
      aural_sync <= aural_meta;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      COLOR_DEPTH_SEL <= 1'b0;
      PIXELS_PER_LONG <= 5'h0;
      BROADCAST_COLOR_EN <= 1'b0;
      BASEBAND_COLOR_EN <= 1'b0;
      AURAL_CARRIER <= 1'b0;
      VIDEO_ACTIVE <= 1'b0;
    end else begin
      COLOR_DEPTH_SEL <= video_configuration[VOC_DEPTH_BIT];
      PIXELS_PER_LONG <= video_configuration[VOC_DEPTH_BIT] ? 5'h10 : 5'h1f; // [R8]
      BROADCAST_COLOR_EN <= video_configuration[VOC_BCAST_BIT]; // [R9]
      BASEBAND_COLOR_EN <= video_configuration[VOC_BASE_BIT]; // [R9]
      AURAL_CARRIER <= aural_sync;
      VIDEO_ACTIVE <= (mode != VOC_MODE_OFF);
    end
  end

  // ==========================================================================
  // Pin routing, one generate entry per pin group
  for (genvar g = 0; g < VOC_GROUPS; g++) begin : gen_group
    always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
        VIDEO_OUT[g*8 +: 8] <= 8'h00;
        VIDEO_OE[g*8 +: 8] <= 8'h00;
      end else if (mode != VOC_MODE_OFF && group_sel == 3'(g)) begin
        VIDEO_OUT[g*8 +: 8] <= lane_data & pin_mask; // [R11]
        VIDEO_OE[g*8 +: 8] <= pin_mask; // [R11]
      end else begin
        VIDEO_OUT[g*8 +: 8] <= 8'h00; // [R4]
        VIDEO_OE[g*8 +: 8] <= 8'h00;
      end
    end
  end
  // One instance per core gives each core its own independent register. [R1]
endmodule : video_configuration_top

// file: sim/tb_video_configuration_top.sv
// Self-checking bench for video_configuration_top over AXI4-Lite.
// Assumes the monitor is bound to the design from its own file.
module tb_video_configuration_top
  import video_configuration_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_SYS = '0, RESET = 1'b1, S_AXI_AWVALID = '0, S_AXI_WVALID = '0, S_AXI_BREADY = '0;
  logic S_AXI_ARVALID = '0, S_AXI_RREADY = '0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_ARREADY, S_AXI_RVALID, COLOR_DEPTH_SEL, BROADCAST_COLOR_EN, BASEBAND_COLOR_EN;
  logic AURAL_CARRIER, VIDEO_ACTIVE;
  logic [31:0] S_AXI_AWADDR = '0, S_AXI_WDATA = '0, S_AXI_ARADDR = '0, S_AXI_RDATA;
  logic [31:0] VIDEO_OUT, VIDEO_OE, s = 32'h16dca;
  logic [3:0] S_AXI_WSTRB = 4'hf, BROADCAST_DATA = '0, BASEBAND_DATA = '0;
  logic [7:0] VGA_DATA = '0, CORE_PLL_A = '0;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [4:0] PIXELS_PER_LONG;
  logic [33:0] q[$];
  logic [1:0] bq[$];
  int err_count = 0, checks = 0;
  video_configuration_top u_video_configuration_top (.CLK_SYS, .RESET, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY, .VGA_DATA, .BROADCAST_DATA, .BASEBAND_DATA, .CORE_PLL_A,
    .COLOR_DEPTH_SEL, .PIXELS_PER_LONG, .BROADCAST_COLOR_EN, .BASEBAND_COLOR_EN, .AURAL_CARRIER,
    .VIDEO_ACTIVE, .VIDEO_OUT, .VIDEO_OE);
  always #25 CLK_SYS = ~CLK_SYS;
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : rnd
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  // Requests change just after a rising edge; ready is judged at the next rising edge.
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    bq.push_back(er);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (aw && S_AXI_AWREADY) begin
        aw = 1'b0;
        S_AXI_AWVALID <= 1'b0;
      end
      if (w && S_AXI_WREADY) begin
        w = 1'b0;
        S_AXI_WVALID <= 1'b0;
      end
    end while (!S_AXI_BVALID);
    S_AXI_BREADY <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    logic ar;
    ar = 1'b1;
    q.push_back(e);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (ar && S_AXI_ARREADY) begin
        ar = 1'b0;
        S_AXI_ARVALID <= 1'b0;
      end
    end while (!S_AXI_RVALID);
    S_AXI_RREADY <= 1'b0;
  endtask : rd
  // Answers are matched to the oldest note at the edge where they are taken.
  always @(posedge CLK_SYS) begin
    if (S_AXI_RVALID && S_AXI_RREADY) begin
      if (q.size() == 0) begin
        err_count++;
        $display("[ERR] %0t read answer with no request", $time);
      end else begin
        chk({S_AXI_RRESP, S_AXI_RDATA}, q.pop_front());
      end
    end
    if (S_AXI_BVALID && S_AXI_BREADY) begin
      if (bq.size() == 0) begin
        err_count++;
        $display("[ERR] %0t write answer with no request", $time);
      end else begin
        chk({32'h0, S_AXI_BRESP}, {32'h0, bq.pop_front()});
      end
    end
  end
  initial begin
    #400000;
    err_count++;
    conclude();
  end
  initial begin
    logic [31:0] v, o;
    logic [7:0] l;
    logic [3:0] c;
    repeat (8) @(posedge CLK_SYS);
    RESET <= 1'b0;
    rd(32'(VOC_ADDR_CONFIG), 34'h0);
    // Twenty passes cover every mode against every group, reserved group 4 too.
    for (int m = 0; m < 20; m++) begin
      v = rnd();
      v[30:29] = 2'(m);
      v[11:9] = 3'(m % 5);
      wr(32'(VOC_ADDR_CONFIG), v, VOC_RESP_OKAY);
      rd(32'(VOC_ADDR_CONFIG), {VOC_RESP_OKAY, v & VOC_WRITE_MASK});
      o = rnd();
      {VGA_DATA, BROADCAST_DATA, BASEBAND_DATA} <= o[15:0];
      // Even passes invert the carriers, so a stuck carrier output cannot pass both ways.
      CORE_PLL_A <= (m % 2 == 1) ? 8'h1 << v[25:23] : ~(8'h1 << v[25:23]);
      repeat (6) @(posedge CLK_SYS);
      l = v[30:29] == 2'h1 ? VGA_DATA : v[30:29] == 2'h2 ? {BROADCAST_DATA, BASEBAND_DATA}
        : {BASEBAND_DATA, BROADCAST_DATA};
      o = (v[30:29] != 2'h0 && m % 5 < 4) ? 32'hff << (8 * (m % 5)) : 32'h0;
      c = {v[28:26], m % 2 == 1};
      chk({COLOR_DEPTH_SEL, BROADCAST_COLOR_EN, BASEBAND_COLOR_EN, AURAL_CARRIER}, c);
      chk(VIDEO_OE, o & ({4{v[7:0]}}));
      chk(VIDEO_OUT, o & ({4{v[7:0] & l}}));
      chk(VIDEO_ACTIVE, v[30:29] != 2'h0);
      rd(32'(VOC_ADDR_STATUS), {VOC_RESP_OKAY, 30'h0, m % 5 < 4, v[30:29] != 2'h0});
      $display("pass %0d done", m);
    end
    wr(32'(VOC_ADDR_STATUS), rnd(), VOC_RESP_SLVERR);
    rd(32'h8, {VOC_RESP_SLVERR, 32'h0});
    $display("refused accesses done");
    // A reset in mid-run must clear a live configuration, not merely an idle one.
    wr(32'(VOC_ADDR_CONFIG), 32'h2000_00ff, VOC_RESP_OKAY);
    repeat (2) @(posedge CLK_SYS);
    RESET <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    RESET <= 1'b0;
    rd(32'(VOC_ADDR_CONFIG), 34'h0);
    chk({VIDEO_ACTIVE, VIDEO_OE}, 34'h0);
    $display("mid-run reset done");
    conclude();
  end
endmodule : tb_video_configuration_top

// file: sim/video_configuration_monitor.sv
// Port checker for the video output configuration block.
// Assumes it is bound to video_configuration_top and sees only that module's ports.
module video_configuration_monitor (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic COLOR_DEPTH_SEL,
  input wire logic [4:0] PIXELS_PER_LONG,
  input wire logic VIDEO_ACTIVE,
  input wire logic [31:0] VIDEO_OUT,
  input wire logic [31:0] VIDEO_OE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  chk_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read not answered");
  chk_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  chk_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write answer dropped");
  // The first edge after reset still shows the cleared count, so it is skipped.
  chk_depth_count: assert property (!$past(RESET) |-> PIXELS_PER_LONG == (COLOR_DEPTH_SEL ? 5'h10 : 5'h1f))
    else $error("pixel count wrong");
  chk_off_quiet: assert property (!VIDEO_ACTIVE |-> VIDEO_OE == 32'h0)
    else $error("pins driven while off");
  chk_pin_gate: assert property ((VIDEO_OUT & ~VIDEO_OE) == 32'h0)
    else $error("video on masked pin");
  chk_one_group: assert property ($onehot0({|VIDEO_OE[31:24], |VIDEO_OE[23:16], |VIDEO_OE[15:8], |VIDEO_OE[7:0]}))
    else $error("several groups driven");
  chk_reset_clear: assert property ($fell(RESET) |-> !VIDEO_ACTIVE && VIDEO_OE == 32'h0)
    else $error("not clear after reset");
endmodule : video_configuration_monitor

bind video_configuration_top video_configuration_monitor u_video_configuration_monitor (.CLK_SYS, .RESET, .S_AXI_ARVALID, .S_AXI_ARREADY,
  .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA, .S_AXI_BVALID, .S_AXI_BREADY, .COLOR_DEPTH_SEL,
  .PIXELS_PER_LONG, .VIDEO_ACTIVE, .VIDEO_OUT, .VIDEO_OE);
